// ===== rtl/bbse_addr.sv
/*
 * Resolves the 8-bit file address of a bit-set into a 12-bit data address.
 * Assumes the caller registers the result; purely combinational.
 */
`include "bbse_map.svh"
`timescale 1ns/1ps
`default_nettype none

module bbse_addr
(
    input wire bbse_pkg::bbse_instr_s instr,
    input wire bbse_pkg::bbse_ctx_s ctx,
    output logic [11:0] addr
);

    always_comb
    begin
        addr = `BBSE_RST_ADDR;
        if (instr.abit)
        begin
            addr = {ctx.bank_ptr, instr.faddr};
        end
        else if (ctx.ext_en && (instr.faddr <= `BBSE_INDEX_MAX))
        begin
            addr = ctx.idx_base + {4'h0, instr.faddr};
        end
        else if (instr.faddr < `BBSE_ACCESS_SPLIT)
        begin
            addr = {`BBSE_ACCESS_LO_BANK, instr.faddr};
        end
        else
        begin
            addr = {`BBSE_ACCESS_HI_BANK, instr.faddr};
        end
    end

endmodule

`default_nettype wire

// ===== rtl/bbse_exec.sv
/*
 * Execution unit for the unconditional relative jump and the file bit
 * force-one instruction, stepped by its own quarter-cycle phase counter.
 * Assumes: pc_in holds the already advanced program counter, data memory
 * answers a read one clock after mem_rd_ff with mem_rdata, and the core
 * presents instructions with instr_valid while instr_ready_ff is high.
 */
// Functional notes
// - A jump loads the advanced program counter plus twice the signed offset.
// - A jump takes two instruction cycles, the second one a no-operation refetch.
// - A bit-set forces one chosen bit of the addressed register and touches nothing else.
// - With the bank bit clear the address lies in the access bank, except for the indexed offsets below.
// - With the bank bit set the bank pointer register selects the storage bank.
// - With extended set on and bank bit clear, addresses up to 95 are indexed offsets.
`include "bbse_map.svh"
`timescale 1ns/1ps
`default_nettype none

module bbse_exec
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic instr_valid,
    input wire logic [15:0] instr,
    input wire logic [20:0] pc_in,
    input wire logic [3:0] bank_pointer_register,
    input wire logic ext_en,
    input wire logic [11:0] idx_base,
    input wire logic [7:0] mem_rdata,
    output logic instr_ready_ff,
    output logic [1:0] qphase_ff,
    output logic pc_load_ff,
    output logic [20:0] pc_next_ff,
    output logic mem_rd_ff,
    output logic mem_wr_ff,
    output logic [11:0] mem_addr_ff,
    output logic [7:0] mem_wdata_ff,
    output logic nop_cycle_ff
);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic bbse_pkg::bbse_instr_s decode(input logic [15:0] w);
        bbse_pkg::bbse_instr_s d;
        d.op = bbse_pkg::BBSE_OP_NONE;
        d.offset = w[`BBSE_JUMP_OFF_HI:0];
        d.bitpos = w[`BBSE_SETB_BIT_HI:`BBSE_SETB_BIT_LO];
        d.abit = w[`BBSE_SETB_ABIT];
        d.faddr = w[`BBSE_SETB_F_HI:0];
        if (w[`BBSE_JUMP_PFX_HI:`BBSE_JUMP_PFX_LO] == `BBSE_JUMP_PFX)
        begin
            d.op = bbse_pkg::BBSE_OP_JUMP;
        end
        else if (w[`BBSE_SETB_OPC_HI:`BBSE_SETB_OPC_LO] == `BBSE_SETB_OPC)
        begin
            d.op = bbse_pkg::BBSE_OP_SETBIT;
        end
        return d;
    endfunction

    function automatic logic [20:0] jump_target(input logic [20:0] pc,
                                                input logic [10:0] off);
        logic [20:0] twice;
        twice = {{9{off[10]}}, off, 1'b0};
        return pc + twice;
    endfunction

    function automatic logic [7:0] force_bit(input logic [7:0] v,
                                             input logic [2:0] b);
        return v | (`BBSE_BIT_ONE << b);
    endfunction

    // ------------------------------------------------------------------
    // quarter-cycle phase counter
    // ------------------------------------------------------------------
    logic [1:0] nxt_qphase;

    always_comb
    begin
        nxt_qphase = qphase_ff + `BBSE_Q_STEP;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            qphase_ff <= `BBSE_Q1;
        end
        else
        begin
            qphase_ff <= nxt_qphase;
        end
    end

    // ------------------------------------------------------------------
    // address resolution
    // ------------------------------------------------------------------
    bbse_pkg::bbse_state_e state_ff;
    bbse_pkg::bbse_state_e nxt_state;
    bbse_pkg::bbse_instr_s cur_ff;
    bbse_pkg::bbse_instr_s nxt_cur;
    bbse_pkg::bbse_instr_s dec;
    bbse_pkg::bbse_ctx_s ctx;
    logic [11:0] res_addr;

    always_comb
    begin
        dec = decode(instr);
        ctx.ext_en = ext_en;
        ctx.bank_ptr = bank_pointer_register;
        ctx.idx_base = idx_base;
    end

    bbse_addr u_addr
    (
        .instr(dec),
        .ctx(ctx),
        .addr(res_addr)
    );

    // ------------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------------
    logic nxt_instr_ready;
    logic nxt_pc_load;
    logic [20:0] nxt_pc_next;
    logic nxt_mem_rd;
    logic nxt_mem_wr;
    logic [11:0] nxt_mem_addr;
    logic [7:0] nxt_mem_wdata;
    logic nxt_nop_cycle;

    always_comb
    begin
        nxt_state = state_ff;
        nxt_cur = cur_ff;
        nxt_pc_load = 1'b0;
        nxt_pc_next = pc_next_ff;
        nxt_mem_rd = 1'b0;
        nxt_mem_wr = 1'b0;
        nxt_mem_addr = mem_addr_ff;
        nxt_mem_wdata = mem_wdata_ff;
        case (state_ff)
            bbse_pkg::BBSE_ST_IDLE:
            begin
                // q1: decode, and for a bit-set start the register read
                if ((qphase_ff == `BBSE_Q1) && instr_valid &&
                    (dec.op != bbse_pkg::BBSE_OP_NONE))
                begin
                    nxt_cur = dec;
                    nxt_state = bbse_pkg::BBSE_ST_EXEC;
                    if (dec.op == bbse_pkg::BBSE_OP_SETBIT)
                    begin
                        nxt_mem_addr = res_addr;
                        nxt_mem_rd = 1'b1;
                    end
                end
            end
            bbse_pkg::BBSE_ST_EXEC:
            begin
                if (qphase_ff == `BBSE_Q3)
                begin
                    if (cur_ff.op == bbse_pkg::BBSE_OP_SETBIT)
                    begin
                        // write back in q4, other bits and flags untouched
                        nxt_mem_wr = 1'b1;
                        nxt_mem_wdata = force_bit(mem_rdata, cur_ff.bitpos);
                    end
                    else
                    begin
                        nxt_pc_load = 1'b1;
                        nxt_pc_next = jump_target(pc_in, cur_ff.offset);
                    end
                end
                if (qphase_ff == `BBSE_Q4)
                begin
                    if (cur_ff.op == bbse_pkg::BBSE_OP_JUMP)
                    begin
                        nxt_state = bbse_pkg::BBSE_ST_FLUSH;
                    end
                    else
                    begin
                        nxt_state = bbse_pkg::BBSE_ST_IDLE;
                    end
                end
            end
            bbse_pkg::BBSE_ST_FLUSH:
            begin
                // whole second cycle is a no-operation refetch
                if (qphase_ff == `BBSE_Q4)
                begin
                    nxt_state = bbse_pkg::BBSE_ST_IDLE;
                end
            end
            default:
            begin
                nxt_state = bbse_pkg::BBSE_ST_IDLE;
            end
        endcase
        nxt_nop_cycle = (nxt_state == bbse_pkg::BBSE_ST_FLUSH);
        nxt_instr_ready = (nxt_state == bbse_pkg::BBSE_ST_IDLE) &&
                          (nxt_qphase == `BBSE_Q1);
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            state_ff <= bbse_pkg::BBSE_ST_IDLE;
            cur_ff <= '0;
            instr_ready_ff <= 1'b0;
            pc_load_ff <= 1'b0;
            pc_next_ff <= `BBSE_RST_PC;
            mem_rd_ff <= 1'b0;
            mem_wr_ff <= 1'b0;
            mem_addr_ff <= `BBSE_RST_ADDR;
            mem_wdata_ff <= `BBSE_RST_DATA;
            nop_cycle_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            cur_ff <= nxt_cur;
            instr_ready_ff <= nxt_instr_ready;
            pc_load_ff <= nxt_pc_load;
            pc_next_ff <= nxt_pc_next;
            mem_rd_ff <= nxt_mem_rd;
            mem_wr_ff <= nxt_mem_wr;
            mem_addr_ff <= nxt_mem_addr;
            mem_wdata_ff <= nxt_mem_wdata;
            nop_cycle_ff <= nxt_nop_cycle;
        end
    end

endmodule

`default_nettype wire

// ===== rtl/bbse_map.svh
/*
 * Constants of the branch and bit-set execution block: opcode fields,
 * quarter-cycle phases, address layout and reset values.
 * Assumes it is included by bare name from the package and the modules.
 */
`ifndef BBSE_MAP_SVH
`define BBSE_MAP_SVH

// ----------------------------------------------------------------------
// opcode fields
// ----------------------------------------------------------------------
`define BBSE_JUMP_PFX 5'h1A
`define BBSE_JUMP_PFX_HI 15
`define BBSE_JUMP_PFX_LO 11
`define BBSE_JUMP_OFF_HI 10
`define BBSE_SETB_OPC 4'h8
`define BBSE_SETB_OPC_HI 15
`define BBSE_SETB_OPC_LO 12
`define BBSE_SETB_BIT_HI 11
`define BBSE_SETB_BIT_LO 9
`define BBSE_SETB_ABIT 8
`define BBSE_SETB_F_HI 7

// ----------------------------------------------------------------------
// quarter-cycle phases
// ----------------------------------------------------------------------
`define BBSE_Q1 2'h0
`define BBSE_Q2 2'h1
`define BBSE_Q3 2'h2
`define BBSE_Q4 2'h3
`define BBSE_Q_STEP 2'h1

// ----------------------------------------------------------------------
// data address layout
// ----------------------------------------------------------------------
`define BBSE_ACCESS_SPLIT 8'h60
`define BBSE_INDEX_MAX 8'h5F
`define BBSE_ACCESS_LO_BANK 4'h0
`define BBSE_ACCESS_HI_BANK 4'hF

// ----------------------------------------------------------------------
// reset values and the bit-set mask
// ----------------------------------------------------------------------
`define BBSE_RST_PC 21'h00000
`define BBSE_RST_ADDR 12'h000
`define BBSE_RST_DATA 8'h00
`define BBSE_BIT_ONE 8'h01

`endif

// ===== rtl/bbse_pkg.sv
/*
 * Types of the branch and bit-set execution block.
 * Assumes bbse_map.svh is on the include path.
 */
`include "bbse_map.svh"
`default_nettype none

package bbse_pkg;

    typedef enum logic [1:0]
    {
        BBSE_OP_NONE = 2'h0,
        BBSE_OP_JUMP = 2'h1,
        BBSE_OP_SETBIT = 2'h2
    } bbse_op_e;

    typedef enum logic [1:0]
    {
        BBSE_ST_IDLE = 2'h0,
        BBSE_ST_EXEC = 2'h1,
        BBSE_ST_FLUSH = 2'h3
    } bbse_state_e;

    typedef struct packed
    {
        bbse_op_e op;
        logic [10:0] offset;
        logic [2:0] bitpos;
        logic abit;
        logic [7:0] faddr;
    } bbse_instr_s;

    typedef struct packed
    {
        logic ext_en;
        logic [3:0] bank_ptr;
        logic [11:0] idx_base;
    } bbse_ctx_s;

endpackage

`default_nettype wire

// ===== tb/bbse_exec_properties.sv
/* Assertions on the ports of bbse_exec.
 * Assumes pc_in and mem_rdata stay steady while an instruction runs. */
`include "bbse_map.svh"
`timescale 1ns/1ps
`default_nettype none
module bbse_chk
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic instr_valid,
    input wire logic [15:0] instr,
    input wire logic [20:0] pc_in,
    input wire logic [3:0] bank_pointer_register,
    input wire logic ext_en,
    input wire logic [11:0] idx_base,
    input wire logic [7:0] mem_rdata,
    input wire logic instr_ready_ff,
    input wire logic [1:0] qphase_ff,
    input wire logic pc_load_ff,
    input wire logic [20:0] pc_next_ff,
    input wire logic mem_rd_ff,
    input wire logic mem_wr_ff,
    input wire logic [11:0] mem_addr_ff,
    input wire logic [7:0] mem_wdata_ff,
    input wire logic nop_cycle_ff
);
    wire logic take = instr_ready_ff && instr_valid && qphase_ff == `BBSE_Q1;
    wire logic tj = take && instr[15:11] == `BBSE_JUMP_PFX;
    wire logic ts = take && instr[15:12] == `BBSE_SETB_OPC;
    wire logic ix = ext_en && instr[7:0] <= `BBSE_INDEX_MAX;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    chk_jump_target: assert property (tj |-> ##3 pc_load_ff &&
        pc_next_ff == $past(pc_in, 1) + {{9{$past(instr[10], 3)}}, $past(instr[10:0], 3), 1'b0})
        else $error("jump target wrong");
    chk_jump_refetch: assert property (tj |-> ##4 nop_cycle_ff[*4] ##1 !nop_cycle_ff)
        else $error("refetch cycle wrong");
    chk_jump_busy: assert property (tj |=> !instr_ready_ff[*7] ##1 instr_ready_ff)
        else $error("jump length wrong");
    chk_setb_cycle: assert property (ts |=> mem_rd_ff ##2 mem_wr_ff && !pc_load_ff)
        else $error("bit set timing wrong");
    chk_setb_data: assert property (ts |-> ##3 mem_wdata_ff ==
        ($past(mem_rdata, 1) | (`BBSE_BIT_ONE << $past(instr[11:9], 3))))
        else $error("bit set data");
    chk_bank_addr: assert property (ts && instr[8] |=>
        mem_addr_ff == {$past(bank_pointer_register), $past(instr[7:0])}) else $error("bank addr");
    chk_index_addr: assert property (ts && !instr[8] && ix |=>
        mem_addr_ff == $past(idx_base) + {4'h0, $past(instr[7:0])}) else $error("index addr");
    chk_access_addr: assert property (ts && !instr[8] && !ix |=> mem_addr_ff ==
        {($past(instr[7:0]) < `BBSE_ACCESS_SPLIT) ? `BBSE_ACCESS_LO_BANK : `BBSE_ACCESS_HI_BANK,
        $past(instr[7:0])}) else $error("access addr");
    chk_bad_opcode: assert property (take && !tj && !ts |=>
        !mem_rd_ff ##2 !mem_wr_ff && !pc_load_ff) else $error("foreign opcode acted on");
    chk_phase_step: assert property ($past(rst_n) |->
        qphase_ff == $past(qphase_ff) + `BBSE_Q_STEP) else $error("phase counter skipped");
    chk_ready_phase: assert property (instr_ready_ff |-> qphase_ff == `BBSE_Q1)
        else $error("ready outside first quarter");
    cover property (tj);
    cover property (ts && !instr[8] && ix);
    cover property (ts && instr[8]);
    cover property (take && !tj && !ts);
endmodule
bind bbse_exec bbse_chk chk_u (.ref_clk(ref_clk), .rst_n(rst_n), .instr_valid(instr_valid),
    .instr(instr), .pc_in(pc_in), .bank_pointer_register(bank_pointer_register), .ext_en(ext_en),
    .idx_base(idx_base), .mem_rdata(mem_rdata), .instr_ready_ff(instr_ready_ff),
    .qphase_ff(qphase_ff), .pc_load_ff(pc_load_ff), .pc_next_ff(pc_next_ff),
    .mem_rd_ff(mem_rd_ff), .mem_wr_ff(mem_wr_ff), .mem_addr_ff(mem_addr_ff),
    .mem_wdata_ff(mem_wdata_ff), .nop_cycle_ff(nop_cycle_ff));
`default_nettype wire

// ===== tb/tb_top.sv
/* Self-checking bench of bbse_exec with a queue of expected results.
 * Assumes the design files and bbse_map.svh are compiled alongside. */
`include "bbse_map.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic ref_clk = 1'b0;
    logic rst_n, instr_valid, ext_en;
    logic [15:0] instr;
    logic [20:0] pc_in, pc_next_ff;
    logic [3:0] bank;
    logic [11:0] idx_base, mem_addr_ff;
    logic [7:0] mem_rdata, mem_wdata_ff;
    logic instr_ready_ff, pc_load_ff, mem_rd_ff, mem_wr_ff, nop_cycle_ff;
    logic [1:0] qphase_ff;
    logic [31:0] seed = 32'hAAB97D49;
    logic [32:0] q[$];
    logic [32:0] e;
    logic [10:0] jt[4] = '{11'h400, 11'h3FF, 11'h000, 11'h7FF};
    int n_mismatch = 0;
    int compares = 0;
    int cycles = 0;
    always #4 ref_clk = ~ref_clk;
    bbse_exec dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .instr_valid(instr_valid), .instr(instr),
        .pc_in(pc_in), .bank_pointer_register(bank), .ext_en(ext_en), .idx_base(idx_base),
        .mem_rdata(mem_rdata), .instr_ready_ff(instr_ready_ff), .qphase_ff(qphase_ff),
        .pc_load_ff(pc_load_ff), .pc_next_ff(pc_next_ff), .mem_rd_ff(mem_rd_ff),
        .mem_wr_ff(mem_wr_ff), .mem_addr_ff(mem_addr_ff), .mem_wdata_ff(mem_wdata_ff),
        .nop_cycle_ff(nop_cycle_ff));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic [11:0] exp_addr(input logic [15:0] w);
        if (w[8])
            return {bank, w[7:0]};
        if (ext_en && w[7:0] <= 8'h5F)
            return idx_base + {4'h0, w[7:0]};
        return {(w[7:0] < 8'h60) ? 4'h0 : 4'hF, w[7:0]};
    endfunction
    task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // waits for a take slot, sets fresh context, notes the outcome, drives one word
    task automatic run(input logic [15:0] w);
        int i;
        i = 0;
        while (instr_ready_ff !== 1'b1 && i < 20)
        begin
            @(posedge ref_clk);
            #1;
            i++;
        end
        seed = xs(seed);
        pc_in = seed[20:0];
        seed = xs(seed);
        {mem_rdata, idx_base, bank, ext_en} = seed[24:0];
        if (w[15:11] == `BBSE_JUMP_PFX)
            q.push_back({1'b1, 11'h0, pc_in + {{9{w[10]}}, w[10:0], 1'b0}});
        else if (w[15:12] == `BBSE_SETB_OPC)
            q.push_back({1'b0, 12'h0, exp_addr(w), mem_rdata | (8'h01 << w[11:9])});
        instr = w;
        instr_valid = 1'b1;
        @(posedge ref_clk);
        #1;
        instr_valid = 1'b0;
    endtask
    // ----------------------------------------
    // result watcher and hang limit
    // ----------------------------------------
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_mismatch++;
            wrap_up();
        end
        else if (pc_load_ff === 1'b1 || mem_wr_ff === 1'b1)
        begin
            if (q.size() == 0)
                check("unexpected output", 33'h1, 33'h0);
            else
            begin
                e = q.pop_front();
                if (pc_load_ff === 1'b1)
                    check("jump target", {1'b1, 11'h0, pc_next_ff}, e);
                else
                    check("bit set", {1'b0, 12'h0, mem_addr_ff, mem_wdata_ff}, e);
            end
        end
    end
    initial
    begin
        {rst_n, instr_valid, ext_en, instr, pc_in, bank, idx_base, mem_rdata} = '0;
        repeat (5) @(posedge ref_clk);
        #1;
        rst_n = 1'b1;
        foreach (jt[k])
            run({`BBSE_JUMP_PFX, jt[k]});
        for (int b = 0; b < 8; b++)
            run({`BBSE_SETB_OPC, b[2:0], 1'b0, 8'h5C + b[7:0]});
        run(16'hD800);
        for (int n = 0; n < 60; n++)
        begin
            seed = xs(seed);
            case (seed[1:0])
                2'h0: run({`BBSE_JUMP_PFX, seed[12:2]});
                2'h1: run({4'h9, seed[13:2]});
                default: run({`BBSE_SETB_OPC, seed[13:2]});
            endcase
        end
        repeat (12) @(posedge ref_clk);
        check("queue drained", {32'h0, q.size() == 0}, 33'h1);
        wrap_up();
    end
endmodule
`default_nettype wire
